// ---- inc/slsq_pkg.sv ----
// Constants and types for the status LED sequencer.
// Assumes a 25 MHz mclk_i and a same-clock UTC time base giving second strobes.
//
// Functional notes
// - Ordinary indications repeat every fifteen seconds.
// - Slots: status 7, satellites 2, clock 2, mode 4.
// - Satellite slot starts at UTC :00/:15/:30/:45.
// - Order: status, satellites, clock, then mode.
// - Startup: two flashes, then thirty seconds steady.
// - Shutdown: steady on until done, then off.
// - Normal status: off 1s, on 5s, off 1s.
// - Abnormal: 350ms flicker, then 50/350ms flashes.
// - Codes 1-7 map battery, card, temperature, disk, saturation, electrode, calibration.
// - Low disk warning five minutes, continuous below 2MB.
// - Flash counts 8 to 14 never used.
// - Fatal error: endless 100ms on, 100ms off.
// - One 250/250ms flash per satellite, four max.
// - Zero satellites: 1.9s on, 0.1s off.
// - Satellites beyond four are not shown.
// - Clock slot: zero to four flashes by clock source.
// - GPS lock needs at least four satellites.
// - Switch to UTC when leap correction arrives.
// - Lost lock falls back to oven oscillator.
// - Recording blocked until clock is synchronized.
// - Mode slot: one to four 900/100ms flashes.
package slsq_pkg;

    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned TICK_NS = 1_000_000;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_NS / 1000;

    // Cycle layout in milliseconds, satellite alignment step in seconds.
    localparam logic [15:0] SLOT_STATUS_MS = 16'h1B58;
    localparam logic [15:0] SLOT_SAT_MS = 16'h07D0;
    localparam logic [15:0] SLOT_CLK_MS = 16'h07D0;
    localparam logic [15:0] SLOT_MODE_MS = 16'h0FA0;
    localparam logic [15:0] SAT_START_MS = SLOT_STATUS_MS;
    localparam logic [15:0] CLK_START_MS = SAT_START_MS + SLOT_SAT_MS;
    localparam logic [15:0] MODE_START_MS = CLK_START_MS + SLOT_CLK_MS;
    localparam logic [15:0] CYCLE_MS = MODE_START_MS + SLOT_MODE_MS;
    localparam logic [5:0] SAT_ALIGN_S = 6'h0F;

    // Pattern timings in milliseconds.
    localparam logic [15:0] NORM_OFF_MS = 16'h03E8;
    localparam logic [15:0] NORM_ON_MS = 16'h1388;
    localparam logic [15:0] ALERT_MS = 16'h015E;
    localparam logic [15:0] FLICK_HALF_MS = 16'h0019;
    localparam logic [15:0] ERR_ON_MS = 16'h0032;
    localparam logic [15:0] ERR_OFF_MS = 16'h015E;
    localparam logic [15:0] FATAL_HALF_MS = 16'h0064;
    localparam logic [15:0] SAT_ON_MS = 16'h00FA;
    localparam logic [15:0] SAT_OFF_MS = 16'h00FA;
    localparam logic [15:0] ZERO_ON_MS = 16'h076C;
    localparam logic [15:0] MODE_ON_MS = 16'h0384;
    localparam logic [15:0] MODE_OFF_MS = 16'h0064;
    localparam logic [15:0] START_ON_MS = 16'h00FA;
    localparam logic [15:0] START_OFF_MS = 16'h00FA;
    localparam logic [15:0] START_STEADY_MS = 16'h7530;
    localparam logic [15:0] START_FLASHES_MS = 16'h0002 * (START_ON_MS + START_OFF_MS);
    localparam logic [15:0] START_TOTAL_MS = START_FLASHES_MS + START_STEADY_MS;
    localparam logic [19:0] LEAP_WAIT_MS = 20'hB71B0;
    localparam logic [19:0] DISK_SHOW_MS = 20'h493E0;

    // Thresholds and counts.
    localparam logic [15:0] BATT_MIN_MV = 16'h2AF8;
    localparam logic [7:0] TEMP_MAX_C = 8'h3C;
    localparam logic [15:0] DISK_AUDIO_MB = 16'h0032;
    localparam logic [15:0] DISK_STD_MB = 16'h000A;
    localparam logic [15:0] DISK_HARD_MB = 16'h0002;
    localparam logic [3:0] SAT_MAX = 4'h4;
    localparam logic [1:0] MODE_RECORD = 2'h2;

    typedef enum logic [2:0] {
        SLSQ_PH_START = 3'b000,
        SLSQ_PH_RUN = 3'b001,
        SLSQ_PH_SHUT = 3'b010,
        SLSQ_PH_OFF = 3'b011,
        SLSQ_PH_FATAL = 3'b100
    } slsq_ph_t;

    // Codes equal the flash count in the clock slot.
    typedef enum logic [2:0] {
        SLSQ_CS_UNINIT = 3'b000,
        SLSQ_CS_RTC = 3'b001,
        SLSQ_CS_SYNC = 3'b010,
        SLSQ_CS_OVEN_CRYSTAL_OSCILLATOR = 3'b011,
        SLSQ_CS_GPS = 3'b100
    } slsq_cs_t;

endpackage : slsq_pkg

// ---- hdl/slsq_tick.sv ----
// Millisecond tick generator for the status LED sequencer.
// Assumes clear_i comes from logic on mclk_i.
`timescale 1ns/1ps
`default_nettype none
module slsq_tick #(
    parameter int unsigned CYCLES = 25000
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Phase control
    input wire logic clear_i,
    output logic tick_o
);
    localparam int unsigned W = (CYCLES > 2) ? $clog2(CYCLES) : 1;
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    generate
        if (CYCLES < 2) begin : g_bad
            $error("slsq_tick: CYCLES must be at least 2");
        end
    endgenerate

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic tick_q;
    logic tick_d;

    // Clearing restarts the millisecond so the cycle phase lands on the UTC second.
    always_comb begin
        cnt_d = (clear_i || cnt_q == LAST) ? '0 : cnt_q + 1'b1;
        tick_d = (cnt_q == LAST) && !clear_i;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_o = tick_q;
endmodule : slsq_tick
`default_nettype wire

// ---- hdl/slsq_top.sv ----
// Status LED sequencer: startup, run cycle, shutdown and fatal patterns.
// Assumes every input comes from logic on mclk_i, so none is synchronised here.
`timescale 1ns/1ps
`default_nettype none
module slsq_top
    import slsq_pkg::*;
#(
    parameter int unsigned TICK_CYCLES_P = slsq_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // UTC time base
    input wire logic utc_sec_stb_i,
    input wire logic [5:0] utc_sec_i,
    // System state
    input wire logic fatal_err_i,
    input wire logic shutdown_req_i,
    input wire logic shutdown_done_i,
    // Status conditions
    input wire logic [15:0] batt_mv_i,
    input wire logic card_present_i,
    input wire logic [7:0] temp_c_i,
    input wire logic [15:0] free_mb_i,
    input wire logic audio_band_survey_i,
    input wire logic sat_rec_inc_i,
    input wire logic electrode_high_i,
    input wire logic cal_failed_i,
    // Satellites and clock
    input wire logic [3:0] sat_count_i,
    input wire logic rtc_valid_i,
    input wire logic leap_rx_i,
    // Instrument mode, 0 setup to 3 idle
    input wire logic [1:0] mode_i,
    // Indications
    output logic led_o,
    output logic [2:0] status_code_o,
    output logic [2:0] clk_src_o,
    output logic utc_locked_o,
    output logic leap_overdue_o,
    output logic record_enable_o
);
    import slsq_pkg::*;

    function automatic logic slsq_flash(input logic [15:0] off, input logic [15:0] per,
                                        input logic [15:0] on_ms, input logic [3:0] n);
        logic [19:0] span;
        span = 20'(per) * 20'(n);
        return (20'(off) < span) && ((off % per) < on_ms);
    endfunction : slsq_flash

    function automatic logic [2:0] slsq_lowest(input logic [6:0] act);
        logic [2:0] code;
        code = 3'h0;
        for (int i = 6; i >= 0; i--) begin
            if (act[i]) begin
                code = 3'(i + 1);
            end
        end
        return code;
    endfunction : slsq_lowest

    logic tick;
    logic align;
    assign align = utc_sec_stb_i && ((utc_sec_i % SAT_ALIGN_S) == 6'h00);

    slsq_tick #(.CYCLES(TICK_CYCLES_P)) u_tick (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .clear_i(align),
        .tick_o(tick)
    );

    // Cycle position and per-cycle snapshot.
    logic [15:0] pos_q, pos_d;
    logic [2:0] code_q, code_d;
    logic [3:0] sat_q, sat_d;
    logic [2:0] cs_snap_q, cs_snap_d;
    logic [1:0] mode_q, mode_d;
    logic satrec_q, satrec_d;
    logic below_q, below_d;
    logic [19:0] disk_tmr_q, disk_tmr_d;
    logic wrap;
    logic below_thr;
    logic disk_act;
    logic [6:0] act;
    slsq_cs_t cs_q, cs_d;

    assign wrap = tick && !align && (pos_q == CYCLE_MS - 16'h0001);
    assign below_thr = free_mb_i < (audio_band_survey_i ? DISK_AUDIO_MB : DISK_STD_MB);

    always_comb begin
        pos_d = pos_q;
        if (align) begin
            pos_d = SAT_START_MS;
        end else if (tick) begin
            pos_d = wrap ? 16'h0000 : pos_q + 16'h0001;
        end
        below_d = below_thr;
        disk_tmr_d = disk_tmr_q;
        if (below_thr && !below_q) begin
            disk_tmr_d = DISK_SHOW_MS;
        end else if (tick && disk_tmr_q != 20'h00000) begin
            disk_tmr_d = disk_tmr_q - 20'h00001;
        end
        disk_act = (mode_i == MODE_RECORD) &&
                   ((free_mb_i < DISK_HARD_MB) || (below_thr && disk_tmr_q != 20'h00000));
        act = {cal_failed_i, electrode_high_i, satrec_q, disk_act,
               temp_c_i > TEMP_MAX_C, !card_present_i, batt_mv_i < BATT_MIN_MV};
        code_d = code_q;
        sat_d = sat_q;
        cs_snap_d = cs_snap_q;
        mode_d = mode_q;
        // A saturation event in the capture cycle is kept for the next cycle.
        satrec_d = satrec_q;
        if (wrap) begin
            code_d = slsq_lowest(act);
            sat_d = (sat_count_i > SAT_MAX) ? SAT_MAX : sat_count_i;
            cs_snap_d = cs_q;
            mode_d = mode_i;
            satrec_d = 1'b0;
        end
        if (sat_rec_inc_i) begin
            satrec_d = 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pos_q <= 16'h0000;
            code_q <= 3'h0;
            sat_q <= 4'h0;
            cs_snap_q <= 3'h0;
            mode_q <= 2'h0;
            satrec_q <= 1'b0;
            below_q <= 1'b0;
            disk_tmr_q <= 20'h00000;
        end else begin
            pos_q <= pos_d;
            code_q <= code_d;
            sat_q <= sat_d;
            cs_snap_q <= cs_snap_d;
            mode_q <= mode_d;
            satrec_q <= satrec_d;
            below_q <= below_d;
            disk_tmr_q <= disk_tmr_d;
        end
    end

    // Top-level phase.
    slsq_ph_t ph_q, ph_d;
    logic [15:0] phcnt_q, phcnt_d;

    always_comb begin
        ph_d = ph_q;
        phcnt_d = tick ? phcnt_q + 16'h0001 : phcnt_q;
        unique case (ph_q)
            SLSQ_PH_START: begin
                if (tick && phcnt_q == START_TOTAL_MS - 16'h0001) begin
                    ph_d = SLSQ_PH_RUN;
                end
            end
            SLSQ_PH_RUN: begin
            end
            SLSQ_PH_SHUT: begin
                if (shutdown_done_i) begin
                    ph_d = SLSQ_PH_OFF;
                end
            end
            SLSQ_PH_OFF: begin
            end
            SLSQ_PH_FATAL: begin
                if (tick && phcnt_q == 16'h0002 * FATAL_HALF_MS - 16'h0001) begin
                    phcnt_d = 16'h0000;
                end
            end
            default: begin
                ph_d = SLSQ_PH_FATAL;
            end
        endcase
        if (shutdown_req_i && (ph_q == SLSQ_PH_START || ph_q == SLSQ_PH_RUN)) begin
            ph_d = SLSQ_PH_SHUT;
        end
        // Fatal overrides every other pattern and restarts the toggle phase.
        if (fatal_err_i && ph_q != SLSQ_PH_FATAL) begin
            ph_d = SLSQ_PH_FATAL;
            phcnt_d = 16'h0000;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ph_q <= SLSQ_PH_START;
            phcnt_q <= 16'h0000;
        end else begin
            ph_q <= ph_d;
            phcnt_q <= phcnt_d;
        end
    end

    // Clock source tracking.
    logic utc_q, utc_d;
    logic [19:0] leap_tmr_q, leap_tmr_d;
    logic over_q, over_d;
    logic rec_q, rec_d;
    logic locked_sats;
    assign locked_sats = sat_count_i >= SAT_MAX;

    always_comb begin
        cs_d = cs_q;
        utc_d = utc_q;
        leap_tmr_d = (tick && leap_tmr_q != 20'h00000) ? leap_tmr_q - 20'h00001 : leap_tmr_q;
        unique case (cs_q)
            SLSQ_CS_UNINIT, SLSQ_CS_RTC, SLSQ_CS_SYNC: begin
                if (locked_sats) begin
                    cs_d = SLSQ_CS_GPS;
                    leap_tmr_d = LEAP_WAIT_MS;
                end else if (sat_count_i != 4'h0) begin
                    cs_d = SLSQ_CS_SYNC;
                end else begin
                    cs_d = rtc_valid_i ? SLSQ_CS_RTC : SLSQ_CS_UNINIT;
                end
            end
            SLSQ_CS_OVEN_CRYSTAL_OSCILLATOR: begin
                if (locked_sats) begin
                    cs_d = SLSQ_CS_GPS;
                end
            end
            SLSQ_CS_GPS: begin
                if (!locked_sats) begin
                    cs_d = SLSQ_CS_OVEN_CRYSTAL_OSCILLATOR;
                end
            end
            default: begin
                cs_d = SLSQ_CS_UNINIT;
            end
        endcase
        if (leap_rx_i && cs_q == SLSQ_CS_GPS) begin
            utc_d = 1'b1;
        end
        // The overdue flag only reports; the switch to UTC still waits for the correction.
        over_d = (cs_q == SLSQ_CS_GPS) && !utc_q && (leap_tmr_q == 20'h00000);
        rec_d = (cs_d == SLSQ_CS_GPS) || (cs_d == SLSQ_CS_OVEN_CRYSTAL_OSCILLATOR);
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cs_q <= SLSQ_CS_UNINIT;
            utc_q <= 1'b0;
            leap_tmr_q <= 20'h00000;
            over_q <= 1'b0;
            rec_q <= 1'b0;
        end else begin
            cs_q <= cs_d;
            utc_q <= utc_d;
            leap_tmr_q <= leap_tmr_d;
            over_q <= over_d;
            rec_q <= rec_d;
        end
    end

    // LED pattern.
    logic led_q, led_d;
    logic [15:0] st_off;

    always_comb begin
        led_d = 1'b0;
        st_off = pos_q - ALERT_MS;
        unique case (ph_q)
            SLSQ_PH_START: begin
                led_d = slsq_flash(phcnt_q, START_ON_MS + START_OFF_MS, START_ON_MS, 4'h2) ||
                        (phcnt_q >= START_FLASHES_MS);
            end
            SLSQ_PH_RUN: begin
                if (pos_q < SAT_START_MS) begin
                    if (code_q == 3'h0) begin
                        led_d = (pos_q >= NORM_OFF_MS) && (pos_q < NORM_OFF_MS + NORM_ON_MS);
                    end else if (pos_q < ALERT_MS) begin
                        led_d = ((pos_q / FLICK_HALF_MS) % 16'h0002) == 16'h0000;
                    end else begin
                        led_d = slsq_flash(st_off, ERR_ON_MS + ERR_OFF_MS, ERR_ON_MS,
                                           {1'b0, code_q});
                    end
                end else if (pos_q < CLK_START_MS) begin
                    if (sat_q == 4'h0) begin
                        led_d = (pos_q - SAT_START_MS) < ZERO_ON_MS;
                    end else begin
                        led_d = slsq_flash(pos_q - SAT_START_MS, SAT_ON_MS + SAT_OFF_MS,
                                           SAT_ON_MS, sat_q);
                    end
                end else if (pos_q < MODE_START_MS) begin
                    led_d = slsq_flash(pos_q - CLK_START_MS, SAT_ON_MS + SAT_OFF_MS,
                                       SAT_ON_MS, {1'b0, cs_snap_q});
                end else begin
                    // mode flashes and off after flashes
                    led_d = slsq_flash(pos_q - MODE_START_MS, MODE_ON_MS + MODE_OFF_MS,
                                       MODE_ON_MS, {2'b00, mode_q} + 4'h1);
                end
            end
            SLSQ_PH_SHUT: begin
                led_d = 1'b1;
            end
            SLSQ_PH_OFF: begin
                led_d = 1'b0;
            end
            SLSQ_PH_FATAL: begin
                led_d = phcnt_q < FATAL_HALF_MS;
            end
            default: begin
                led_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            led_q <= 1'b0;
        end else begin
            led_q <= led_d;
        end
    end

    assign led_o = led_q;
    assign status_code_o = code_q;
    assign clk_src_o = cs_q;
    assign utc_locked_o = utc_q;
    assign leap_overdue_o = over_q;
    assign record_enable_o = rec_q;

    property p_cycle_wrap;
        @(posedge mclk_i) disable iff (rst_i) wrap |=> pos_q == 16'h0000;
    endproperty
    a_cycle_wrap: assert property (p_cycle_wrap)
        else $error("cycle did not wrap");

    property p_align;
        @(posedge mclk_i) disable iff (rst_i) align |=> (pos_q == SAT_START_MS) && !tick;
    endproperty
    a_align: assert property (p_align)
        else $error("satellite slot not aligned");

    property p_normal_on;
        @(posedge mclk_i) disable iff (rst_i)
            ph_q == SLSQ_PH_RUN && code_q == 3'h0 && pos_q >= NORM_OFF_MS &&
            pos_q < NORM_OFF_MS + NORM_ON_MS |=> led_q;
    endproperty
    a_normal_on: assert property (p_normal_on)
        else $error("normal light missing");

    property p_shut;
        @(posedge mclk_i) disable iff (rst_i) ph_q == SLSQ_PH_SHUT |=> led_q;
    endproperty
    a_shut: assert property (p_shut)
        else $error("LED dark during shutdown");

    property p_fatal;
        @(posedge mclk_i) disable iff (rst_i)
            ph_q == SLSQ_PH_FATAL |=> led_q == ($past(phcnt_q) < FATAL_HALF_MS);
    endproperty
    a_fatal: assert property (p_fatal)
        else $error("fatal toggle wrong");

    property p_fallback;
        @(posedge mclk_i) disable iff (rst_i) cs_q == SLSQ_CS_GPS && !locked_sats |=>
            cs_q == SLSQ_CS_OVEN_CRYSTAL_OSCILLATOR;
    endproperty
    a_fallback: assert property (p_fallback)
        else $error("no oscillator fallback");

    property p_lock_needs_four;
        @(posedge mclk_i) disable iff (rst_i) cs_q != SLSQ_CS_GPS && !locked_sats |=>
            cs_q != SLSQ_CS_GPS;
    endproperty
    a_lock_needs_four: assert property (p_lock_needs_four)
        else $error("lock without four");

    property p_rec_gate;
        @(posedge mclk_i) disable iff (rst_i)
            cs_q == SLSQ_CS_UNINIT ##1 cs_q == SLSQ_CS_UNINIT |-> !record_enable_o;
    endproperty
    a_rec_gate: assert property (p_rec_gate)
        else $error("recording allowed unsynchronised");

    property p_priority;
        @(posedge mclk_i) disable iff (rst_i)
            wrap && batt_mv_i < BATT_MIN_MV |=> code_q == 3'h1;
    endproperty
    a_priority: assert property (p_priority)
        else $error("lowest code not chosen");

    property p_zero_sat_gap;
        @(posedge mclk_i) disable iff (rst_i)
            ph_q == SLSQ_PH_RUN && sat_q == 4'h0 && pos_q >= SAT_START_MS + ZERO_ON_MS &&
            pos_q < CLK_START_MS |=> !led_q;
    endproperty
    a_zero_sat_gap: assert property (p_zero_sat_gap)
        else $error("zero satellite gap lit");

    property p_start_steady;
        @(posedge mclk_i) disable iff (rst_i)
            ph_q == SLSQ_PH_START && phcnt_q >= START_FLASHES_MS |=> led_q;
    endproperty
    a_start_steady: assert property (p_start_steady)
        else $error("startup steady light off");
endmodule : slsq_top
`default_nettype wire

// ---- testbench/slsq_led_watch.sv ----
// Observer standing in for a person watching the LED: counts flashes, times the last one.
// Assumes led_i is launched from mclk_i; clr_i is held high until the LED is known.
`timescale 1ns/1ps
`default_nettype none
module slsq_led_watch (
    // Clock and window control
    input wire logic mclk_i,
    input wire logic clr_i,
    // LED and what was seen
    input wire logic led_i,
    output logic [7:0] flash_cnt_o,
    output logic [15:0] on_len_o
);
    logic led_q;
    logic [15:0] run_q;
    // A flash counts at its rising edge, so one lit across a clear is not counted twice.
    always_ff @(posedge mclk_i) begin
        led_q <= led_i;
        run_q <= led_i ? run_q + 16'h0001 : 16'h0000;
        if (led_q && !led_i) begin
            on_len_o <= run_q;
        end
        if (clr_i) begin
            flash_cnt_o <= 8'h00;
        end else if (led_i && !led_q) begin
            flash_cnt_o <= flash_cnt_o + 8'h01;
        end
    end
endmodule : slsq_led_watch
`default_nettype wire

// ---- testbench/status_led_sequencer_tb.sv ----
// Self-checking bench for the status LED sequencer, timed in scaled milliseconds.
// Assumes a 2-cycle millisecond so that startup and one cycle fit the run.
`timescale 1ns/1ps
`default_nettype none
module status_led_sequencer_tb;
    import slsq_pkg::*;
    localparam int TK = 2;
    int errors = 0;
    int check_count = 0;
    int cyc = 0;
    int ref_c = 0;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic stb = 1'b0;
    logic [5:0] sec = 6'h00;
    logic fatal = 1'b0;
    logic sd_req = 1'b0;
    logic sd_done = 1'b0;
    logic [7:0] temp = 8'h14;
    logic [15:0] batt = 16'h3000;
    logic elec = 1'b0;
    logic [3:0] sats = 4'h0;
    logic rtc = 1'b0;
    logic leap = 1'b0;
    logic [1:0] mode = 2'h0;
    logic clr = 1'b1;
    logic led, locked, rec, over;
    logic [2:0] code, src;
    logic [7:0] cnt;
    logic [15:0] on_len;

    slsq_top #(.TICK_CYCLES_P(TK)) u_dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .utc_sec_stb_i(stb), .utc_sec_i(sec),
        .fatal_err_i(fatal), .shutdown_req_i(sd_req), .shutdown_done_i(sd_done),
        .batt_mv_i(batt), .card_present_i(1'b1), .temp_c_i(temp), .free_mb_i(16'hFFFF),
        .audio_band_survey_i(1'b0), .sat_rec_inc_i(1'b0), .electrode_high_i(elec),
        .cal_failed_i(1'b0), .sat_count_i(sats), .rtc_valid_i(rtc), .leap_rx_i(leap),
        .mode_i(mode), .led_o(led), .status_code_o(code), .clk_src_o(src),
        .utc_locked_o(locked), .leap_overdue_o(over), .record_enable_o(rec)
    );
    slsq_led_watch u_obs (
        .mclk_i(mclk_i), .clr_i(clr), .led_i(led), .flash_cnt_o(cnt), .on_len_o(on_len)
    );

    initial begin
        forever #20 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) cyc <= cyc + 1;

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic to_ms(input int ms);
        while (cyc < ref_c + ms * TK) @(negedge mclk_i);
    endtask : to_ms

    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : wait_n

    task automatic clear_obs();
        clr = 1'b1;
        wait_n(1);
        clr = 1'b0;
    endtask : clear_obs

    task automatic do_reset();
        rst_i = 1'b1;
        clr = 1'b1;
        wait_n(20);
        chk("led in reset", 16'h0000, {15'h0000, led});
        rst_i = 1'b0;
        clr = 1'b0;
        ref_c = cyc;
    endtask : do_reset

    task automatic close_out();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    initial begin
        wait_n(108000);
        errors++;
        close_out();
    end

    initial begin
        do_reset();
        to_ms(300);
        sd_req = 1'b1;
        wait_n(3);
        chk("led shutdown", 16'h0001, {15'h0000, led});
        to_ms(800);
        chk("led shutdown", 16'h0001, {15'h0000, led});
        sd_done = 1'b1;
        wait_n(3);
        chk("led after shutdown", 16'h0000, {15'h0000, led});
        to_ms(1500);
        chk("led after shutdown", 16'h0000, {15'h0000, led});
        sd_req = 1'b0;
        sd_done = 1'b0;
        do_reset();
        to_ms(100);
        chk("startup led", 16'h0001, {15'h0000, led});
        to_ms(900);
        chk("startup flash", 16'h01F4, on_len);
        batt = 16'h2AF7;
        to_ms(16000);
        chk("startup flashes", 16'h0003, {8'h00, cnt});
        chk("startup steady", 16'h0001, {15'h0000, led});
        chk("status code", 16'h0001, {13'h0000, code});
        batt = 16'h2AF8;
        // A strobe at second 45 in startup sets the phase so the run opens 100 ms
        // before the satellite slot, with the LED dark in between.
        to_ms(16100);
        sec = 6'h2D;
        stb = 1'b1;
        clr = 1'b1;
        wait_n(1);
        stb = 1'b0;
        clr = 1'b0;
        ref_c = cyc;
        to_ms(16950);
        chk("aligned led", 16'h0000, {15'h0000, led});
        chk("zero sat pulse", 16'h0ED8, on_len);
        to_ms(19000);
        chk("empty clock slot", 16'h0001, {8'h00, cnt});
        rtc = 1'b1;
        wait_n(3);
        chk("clock source", 16'h0001, {13'h0000, src});
        sats = 4'h2;
        wait_n(3);
        chk("clock source", 16'h0002, {13'h0000, src});
        chk("record enable", 16'h0000, {15'h0000, rec});
        sats = 4'h6;
        wait_n(3);
        chk("clock source", 16'h0004, {13'h0000, src});
        chk("record enable", 16'h0001, {15'h0000, rec});
        chk("leap overdue", 16'h0000, {15'h0000, over});
        leap = 1'b1;
        wait_n(1);
        leap = 1'b0;
        wait_n(2);
        chk("utc locked", 16'h0001, {15'h0000, locked});
        mode = 2'h2;
        temp = 8'h46;
        elec = 1'b1;
        to_ms(22000);
        chk("mode flashes", 16'h0002, {8'h00, cnt});
        chk("mode width", 16'h0708, on_len);
        clear_obs();
        to_ms(29990);
        chk("status flashes", 16'h000A, {8'h00, cnt});
        chk("error flash", 16'h0064, on_len);
        chk("status code", 16'h0003, {13'h0000, code});
        clear_obs();
        to_ms(31990);
        chk("sat flashes", 16'h0004, {8'h00, cnt});
        chk("sat width", 16'h01F4, on_len);
        clear_obs();
        to_ms(33990);
        chk("clock flashes", 16'h0004, {8'h00, cnt});
        sats = 4'h2;
        wait_n(3);
        chk("clock source", 16'h0003, {13'h0000, src});
        chk("record enable", 16'h0001, {15'h0000, rec});
        fatal = 1'b1;
        clear_obs();
        to_ms(34990);
        chk("fatal flashes", 16'h0005, {8'h00, cnt});
        chk("fatal width", 16'h00C8, on_len);
        close_out();
    end
endmodule : status_led_sequencer_tb
`default_nettype wire
